// ### wakeup_timer.v
// Overview of operation
// - One 24-bit up-counter, readable as three read-only count bytes.
// - Counter keeps running in stop mode; a match wakes the chip when the match interrupt is enabled.
// - Counting and match events continue in normal, idle and stop modes.
// - Counting clock is the internal ring oscillator, never the system oscillator.
// - Oscillator may also be divided by 2, 4 or 16.
// - Full 24-bit equality compare of count against the reference value.
// - On match the counter clears to zero and counts up again.
// - Match requests interrupt level two only while the match interrupt is enabled, serviced at vector EEH.
// - Match sets pending bit 0 of the control register to one.
// - Pending stays set until software writes zero to control bit 0.
// - Control register holds a counter clear and a match interrupt enable.
// - Reset clears the control register to zero, disabling the interrupt.
// - Count bytes are read-only; writes leave the count untouched.
// - Three read/write reference bytes form the 24-bit compare value.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_regs.vh"

module wakeup_timer #(
  parameter CNT_W  = 24,
  parameter ADDR_W = 12
) (
  input  wire              i_clk,
  input  wire              i_sys_rst,
  input  wire              i_ring_osc,
  input  wire [ADDR_W-1:0] i_awaddr,
  input  wire              i_awvalid,
  output wire              o_awready,
  input  wire [31:0]       i_wdata,
  input  wire [3:0]        i_wstrb,
  input  wire              i_wvalid,
  output wire              o_wready,
  output wire [1:0]        o_bresp,
  output wire              o_bvalid,
  input  wire              i_bready,
  input  wire [ADDR_W-1:0] i_araddr,
  input  wire              i_arvalid,
  output wire              o_arready,
  output wire [31:0]       o_rdata,
  output wire [1:0]        o_rresp,
  output wire              o_rvalid,
  input  wire              i_rready,
  output wire              o_irq,
  output wire              o_irq_level_two,
  output wire [7:0]        o_irq_vector,
  output wire              o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator synchroniser and prescaler.

  // State of the timer side.
  reg              osc_meta_ff;
  reg              osc_sync_ff;
  reg              osc_prev_ff;
  reg  [3:0]       pre_ff;
  reg  [CNT_W-1:0] count_ff;
  reg  [CNT_W-1:0] ref_ff;
  reg  [7:0]       ctrl_ff;
  reg  [7:0]       irq_status_ff;
  reg  [7:0]       irq_mask_ff;
  reg              irq_ff;
  reg              irq_two_ff;
  reg              wake_ff;
  reg  [7:0]       vector_ff;
  reg  [3:0]       pre_last;
  reg  [3:0]       nxt_pre;
  reg  [CNT_W-1:0] nxt_count;
  wire             osc_rise;
  wire             tick;
  wire             match;
  wire             ctrl_wr;
  wire             status_wr;
  wire             mask_wr;
  wire             clear_cmd;

  // Two flops bring the oscillator in; the third only feeds edge detection.
  // The oscillator is free running and unrelated to i_clk, so nothing but the
  // second flop may look at the first. Each oscillator half period must span
  // several system clocks, or an edge is lost between samples.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= i_ring_osc;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  // One-cycle pulse on each rising oscillator edge.
  assign osc_rise = osc_sync_ff & ~osc_prev_ff;

  // Last prescaler value for the selected division.
  // The prescaler compares with greater-or-equal, so switching to a smaller
  // division while it stands above the new limit gives one early tick
  // instead of a wrap through sixteen states.
  always @* begin
    case (ctrl_ff[`WT_CTRL_DIV_MSB:`WT_CTRL_DIV_LSB])
      `WT_DIV_BY_2:  pre_last = `WT_PRE_LAST_2;
      `WT_DIV_BY_4:  pre_last = `WT_PRE_LAST_4;
      `WT_DIV_BY_16: pre_last = `WT_PRE_LAST_16;
      default:       pre_last = `WT_PRE_LAST_1;
    endcase
  end

  // A software clear in the same cycle swallows the tick, so no match is seen.
  assign tick  = osc_rise & (pre_ff >= pre_last);
  assign match = tick & ~clear_cmd & (count_ff == ref_ff);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  // State and decode of the bus side.
  reg              awready_ff;
  reg              aw_hold_ff;
  reg  [7:0]       wr_idx_ff;
  reg              wready_ff;
  reg              w_hold_ff;
  reg  [31:0]      wdata_ff;
  reg              wlane_ff;
  reg              bvalid_ff;
  reg  [1:0]       bresp_ff;
  reg              arready_ff;
  reg              rvalid_ff;
  reg  [31:0]      rdata_ff;
  reg  [1:0]       rresp_ff;
  reg  [7:0]       rd_byte;
  reg              rd_hit;
  reg              wr_hit;
  wire [7:0]       rd_idx;
  wire             do_write;
  wire             wr_en;
  wire [7:0]       wbyte;

  // Register index, write qualifier and written byte.
  assign rd_idx   = i_araddr[9:2];
  assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_en    = do_write & wlane_ff;
  assign wbyte    = wdata_ff[7:0];

  // Write strobes for the registers that act on what software writes.
  assign ctrl_wr   = wr_en & (wr_idx_ff == `WT_IDX_CONTROL);
  assign status_wr = wr_en & (wr_idx_ff == `WT_IDX_IRQ_STATUS);
  assign mask_wr   = wr_en & (wr_idx_ff == `WT_IDX_IRQ_MASK);
  assign clear_cmd = ctrl_wr & wbyte[`WT_CTRL_CLEAR_BIT];

  // Address and data are taken independently, then answered together.
  // Only one write is outstanding: both readies stay low from their take
  // until the response handshake, so a second address cannot overtake.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      awready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
      wready_ff  <= 1'b1;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= 32'h00000000;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `WT_RESP_OKAY;
    end else begin
      if (i_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_hold_ff <= 1'b1;
        wr_idx_ff  <= (i_awaddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) ?
                      i_awaddr[9:2] : 8'h00;
      end
      if (i_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_hold_ff <= 1'b1;
        wdata_ff  <= i_wdata;
        wlane_ff  <= i_wstrb[0];
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `WT_RESP_OKAY : `WT_RESP_SLVERR;
      end
      if (bvalid_ff && i_bready) begin
        bvalid_ff  <= 1'b0;
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Decode of write index.
  always @* begin
    case (wr_idx_ff)
      `WT_IDX_COUNT_HIGH,
      `WT_IDX_COUNT_MIDDLE,
      `WT_IDX_COUNT_LOW,
      `WT_IDX_REF_HIGH,
      `WT_IDX_REF_MIDDLE,
      `WT_IDX_REF_LOW,
      `WT_IDX_CONTROL,
      `WT_IDX_IRQ_STATUS,
      `WT_IDX_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; bits above the low byte read as zero.
  // Count bytes are live, not latched: software reading the three bytes
  // while the counter runs may see a carry between two of its reads.
  always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `WT_IDX_COUNT_HIGH:   rd_byte = count_ff[23:16];
      `WT_IDX_COUNT_MIDDLE: rd_byte = count_ff[15:8];
      `WT_IDX_COUNT_LOW:    rd_byte = count_ff[7:0];
      `WT_IDX_REF_HIGH:     rd_byte = ref_ff[23:16];
      `WT_IDX_REF_MIDDLE:   rd_byte = ref_ff[15:8];
      `WT_IDX_REF_LOW:      rd_byte = ref_ff[7:0];
      `WT_IDX_CONTROL:      rd_byte = ctrl_ff;
      `WT_IDX_IRQ_STATUS:   rd_byte = irq_status_ff;
      `WT_IDX_IRQ_MASK:     rd_byte = irq_mask_ff;
      default:              rd_hit  = 1'b0;
    endcase
    if (i_araddr[ADDR_W-1:10] != {(ADDR_W-10){1'b0}}) begin
      rd_hit  = 1'b0;
      rd_byte = 8'h00;
    end
  end

  // Read answer one cycle after the address is taken.
  // A new address is refused until the data has been handed over.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `WT_RESP_OKAY;
    end else begin
      if (i_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= {24'h000000, rd_byte};
        rresp_ff   <= rd_hit ? `WT_RESP_OKAY : `WT_RESP_SLVERR;
      end else if (rvalid_ff && i_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, reference and control.

  // Next prescaler and count; a clear beats a tick, and a match restarts from zero.
  always @* begin
    nxt_pre   = pre_ff;
    nxt_count = count_ff;
    if (clear_cmd) begin
      nxt_pre   = 4'h0;
      nxt_count = {CNT_W{1'b0}};
    end else if (osc_rise) begin
      nxt_pre = tick ? 4'h0 : pre_ff + 4'h1;
      if (match) begin
        nxt_count = {CNT_W{1'b0}};
      end else if (tick) begin
        nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Counter runs whatever the chip mode; a clear, a match or a wrap past all ones zeroes it.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_ff   <= 4'h0;
      count_ff <= {CNT_W{1'b0}};
    end else begin
      pre_ff   <= nxt_pre;
      count_ff <= nxt_count;
    end
  end

  // Reference bytes; count byte writes are accepted and dropped.
  // A reference set below the running count lets the counter go the whole
  // 24-bit range round before the next match.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_ff <= `WT_REF_RESET;
    end else if (wr_en) begin
      case (wr_idx_ff)
        `WT_IDX_REF_HIGH:   ref_ff[23:16] <= wbyte;
        `WT_IDX_REF_MIDDLE: ref_ff[15:8]  <= wbyte;
        `WT_IDX_REF_LOW:    ref_ff[7:0]   <= wbyte;
        default:            ref_ff <= ref_ff;
      endcase
    end
  end

  // Control: pending clears on a written zero, but a match in that cycle wins.
  // Writing one to the pending bit is ignored, so a read-modify-write that reads
  // it set keeps it, but one that read zero before a racing match clears the event.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_ff <= `WT_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_ff[7:1] <= {wbyte[7:3], 1'b0, wbyte[`WT_CTRL_ENABLE_BIT]};
        if (!wbyte[`WT_CTRL_PENDING_BIT]) begin
          ctrl_ff[`WT_CTRL_PENDING_BIT] <= 1'b0;
        end
      end
      if (match) begin
        ctrl_ff[`WT_CTRL_PENDING_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and outputs.

  // Status bits are write-one-to-clear; a match in the same cycle wins.
  // The mask only gates the level output; status keeps recording events.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_status_ff <= `WT_IRQ_STATUS_RESET;
      irq_mask_ff   <= `WT_IRQ_MASK_RESET;
    end else begin
      if (status_wr) begin
        irq_status_ff <= irq_status_ff & ~wbyte;
      end
      if (mask_wr) begin
        irq_mask_ff <= wbyte;
      end
      if (match) begin
        irq_status_ff[`WT_IRQ_MATCH_BIT] <= 1'b1;
      end
    end
  end

  // Registered interrupt and wake outputs.
  // Wake is a one-cycle pulse straight from the match, a cycle ahead of the
  // level request, so a sleeping chip can restart before it polls.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_ff     <= 1'b0;
      irq_two_ff <= 1'b0;
      wake_ff    <= 1'b0;
      vector_ff  <= `WT_IRQ_VECTOR;
    end else begin
      irq_ff     <= |(irq_status_ff & irq_mask_ff);
      irq_two_ff <= ctrl_ff[`WT_CTRL_PENDING_BIT] & ctrl_ff[`WT_CTRL_ENABLE_BIT];
      wake_ff    <= match & ctrl_ff[`WT_CTRL_ENABLE_BIT];
      vector_ff  <= `WT_IRQ_VECTOR;
    end
  end

  // Every output comes straight from a flip-flop.
  assign o_awready       = awready_ff;
  assign o_wready        = wready_ff;
  assign o_bvalid        = bvalid_ff;
  assign o_bresp         = bresp_ff;
  assign o_arready       = arready_ff;
  assign o_rvalid        = rvalid_ff;
  assign o_rdata         = rdata_ff;
  assign o_rresp         = rresp_ff;
  assign o_irq           = irq_ff;
  assign o_irq_level_two = irq_two_ff;
  assign o_irq_vector    = vector_ff;
  assign o_wake          = wake_ff;

endmodule // wakeup_timer

`default_nettype wire

// ### wakeup_timer_regs.vh
`ifndef WAKEUP_TIMER_REGS_VH
`define WAKEUP_TIMER_REGS_VH

// Register indices; the AXI byte address is four times the index.
`define WT_IDX_COUNT_HIGH     8'hf6
`define WT_IDX_COUNT_MIDDLE   8'hf7
`define WT_IDX_COUNT_LOW      8'hf8
`define WT_IDX_REF_HIGH       8'hf9
`define WT_IDX_REF_MIDDLE     8'hfa
`define WT_IDX_REF_LOW        8'hfb
`define WT_IDX_CONTROL        8'hfc
`define WT_IDX_IRQ_STATUS     8'hfd
`define WT_IDX_IRQ_MASK       8'hfe

// Fields of timer_control.
`define WT_CTRL_PENDING_BIT   0
`define WT_CTRL_ENABLE_BIT    1
`define WT_CTRL_CLEAR_BIT     2
`define WT_CTRL_DIV_LSB       3
`define WT_CTRL_DIV_MSB       4
`define WT_CTRL_RESET         8'h00

// Divider select codes and last prescaler value for each.
`define WT_DIV_BY_1           2'h0
`define WT_DIV_BY_2           2'h1
`define WT_DIV_BY_4           2'h2
`define WT_DIV_BY_16          2'h3
`define WT_PRE_LAST_1         4'h0
`define WT_PRE_LAST_2         4'h1
`define WT_PRE_LAST_4         4'h3
`define WT_PRE_LAST_16        4'hf

// Interrupt status and mask layout, reset values.
`define WT_IRQ_MATCH_BIT      0
`define WT_IRQ_STATUS_RESET   8'h00
`define WT_IRQ_MASK_RESET     8'h00
`define WT_REF_RESET          24'h000000
`define WT_IRQ_VECTOR         8'hee

// AXI responses.
`define WT_RESP_OKAY          2'h0
`define WT_RESP_SLVERR        2'h2

`endif

// ### wakeup_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the bus handshakes and the level-two request, vector and wake outputs of the wakeup timer.
module wakeup_timer_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        i_rready,
  input wire logic        o_irq_level_two,
  input wire logic [7:0]  o_irq_vector,
  input wire logic        o_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Steps of a write and of a stalled answer.
  sequence s_wr_take; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  sequence s_b_wait; o_bvalid && !i_bready; endsequence
  sequence s_r_wait; o_rvalid && !i_rready; endsequence
  property p_wr_answer; s_wr_take |-> ##2 o_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  property p_b_hold; s_b_wait |=> o_bvalid && $stable(o_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_answer; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_r_hold; s_r_wait |=> o_rvalid && $stable(o_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_byte; o_rvalid |-> o_rdata[31:8] == 24'h000000 && !o_arready; endproperty
  a_r_byte: assert property (p_r_byte) else $error("read data wider than a byte");
  property p_vector; o_irq_vector == 8'hee; endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");
  property p_wake_pulse; o_wake |=> !o_wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  property p_wake_req; o_wake |=> o_irq_level_two; endproperty
  a_wake_req: assert property (p_wake_req) else $error("wake without request");
endmodule // wakeup_timer_chk
bind wakeup_timer wakeup_timer_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .o_bresp(o_bresp), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_rready(i_rready),
  .o_irq_level_two(o_irq_level_two), .o_irq_vector(o_irq_vector), .o_wake(o_wake));
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_regs.vh"
module testbench;
  logic        i_clk, i_sys_rst, i_ring_osc, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, rnd;
  logic [3:0]  i_wstrb;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_irq_level_two, o_wake;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  wire  [7:0]  o_irq_vector;
  logic [33:0] q[$];
  int          fails, n_tests, cyc, wakes;
  bit          late;
  wakeup_timer u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ring_osc(i_ring_osc),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_irq(o_irq), .o_irq_level_two(o_irq_level_two),
    .o_irq_vector(o_irq_vector), .o_wake(o_wake));
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one seen value with its expected value.
  task check(input string nm, input [33:0] s, input [33:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Writes one register and notes the expected response.
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    bit aw, w;
    q.push_back({r, 32'h0});
    aw = 0;
    w = 0;
    i_awaddr <= {2'h0, a, 2'h0};
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= !late;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) begin aw = 1; i_awvalid <= 0; end
      if (i_wvalid && o_wready) begin w = 1; i_wvalid <= 0; end
    end
    do @(posedge i_clk); while (!o_bvalid);
    if (late) begin
      @(posedge i_clk);
      i_bready <= 1;
      do @(posedge i_clk); while (!o_bvalid);
    end
    i_bready <= 0;
    @(posedge i_clk);
  endtask
  // Reads one register and notes the expected response and byte.
  task rd(input [7:0] a, input [7:0] d, input [1:0] r);
    q.push_back({r, 24'h0, d});
    i_araddr <= {2'h0, a, 2'h0};
    i_arvalid <= 1;
    i_rready <= !late;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 0;
    while (!o_rvalid) @(posedge i_clk);
    if (late) begin
      @(posedge i_clk);
      i_rready <= 1;
      do @(posedge i_clk); while (!o_rvalid);
    end
    i_rready <= 0;
    @(posedge i_clk);
  endtask
  // Gives n oscillator periods, each slow against the system clock.
  task tk(input int n);
    repeat (n) begin
      i_ring_osc <= 1;
      repeat (6) @(posedge i_clk);
      i_ring_osc <= 0;
      repeat (6) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation.
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // Takes the oldest note whenever an answer is handed over.
  always @(posedge i_clk) begin
    if (o_bvalid && i_bready) check("bus write", {o_bresp, 32'h0}, q.pop_front());
    if (o_rvalid && i_rready) check("bus read", {o_rresp, o_rdata}, q.pop_front());
    if (o_wake) wakes++;
  end
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {i_sys_rst, i_ring_osc, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h40;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    i_wstrb = 4'hf;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 0;
    void'($urandom(32'h454a));
    rd(`WT_IDX_CONTROL, 8'h00, `WT_RESP_OKAY);
    rd(`WT_IDX_IRQ_MASK, 8'h00, `WT_RESP_OKAY);
    rnd = $urandom;
    // Late ready on both answers: the design must hold them until taken.
    late = 1;
    wr(`WT_IDX_REF_MIDDLE, rnd, `WT_RESP_OKAY);
    rd(`WT_IDX_REF_MIDDLE, rnd[7:0], `WT_RESP_OKAY);
    late = 0;
    wr(`WT_IDX_REF_MIDDLE, 32'h0, `WT_RESP_OKAY);
    wr(`WT_IDX_REF_HIGH, 32'h1, `WT_RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr(`WT_IDX_CONTROL, {27'h0, c[1:0], 3'h4}, `WT_RESP_OKAY);
      tk(16);
      rd(`WT_IDX_COUNT_LOW, 8'd16 >> ((c == 3) ? 4 : c), `WT_RESP_OKAY);
    end
    wr(`WT_IDX_COUNT_LOW, 32'haa, `WT_RESP_OKAY);
    rd(`WT_IDX_COUNT_LOW, 8'h01, `WT_RESP_OKAY);
    wr(`WT_IDX_REF_HIGH, 32'h0, `WT_RESP_OKAY);
    wr(`WT_IDX_REF_LOW, 32'h2, `WT_RESP_OKAY);
    wr(`WT_IDX_IRQ_MASK, 32'h1, `WT_RESP_OKAY);
    wr(`WT_IDX_CONTROL, 32'h6, `WT_RESP_OKAY);
    tk(2);
    rd(`WT_IDX_COUNT_LOW, 8'h02, `WT_RESP_OKAY);
    tk(1);
    rd(`WT_IDX_COUNT_LOW, 8'h00, `WT_RESP_OKAY);
    rd(`WT_IDX_CONTROL, 8'h03, `WT_RESP_OKAY);
    check("level two request", o_irq_level_two, 1);
    wr(`WT_IDX_CONTROL, 32'h2, `WT_RESP_OKAY);
    rd(`WT_IDX_CONTROL, 8'h02, `WT_RESP_OKAY);
    check("level two request", o_irq_level_two, 0);
    check("interrupt", o_irq, 1);
    wr(`WT_IDX_IRQ_STATUS, 32'h1, `WT_RESP_OKAY);
    rd(`WT_IDX_IRQ_STATUS, 8'h00, `WT_RESP_OKAY);
    check("interrupt", o_irq, 0);
    wr(`WT_IDX_CONTROL, 32'h0, `WT_RESP_OKAY);
    tk(3);
    rd(`WT_IDX_CONTROL, 8'h01, `WT_RESP_OKAY);
    check("level two request", o_irq_level_two, 0);
    check("interrupt", o_irq, 1);
    wr(`WT_IDX_IRQ_MASK, 32'h0, `WT_RESP_OKAY);
    rd(`WT_IDX_IRQ_MASK, 8'h00, `WT_RESP_OKAY);
    check("interrupt", o_irq, 0);
    check("wake pulses", wakes, 1);
    // Reset in mid-run while pending is set: control must come back as zero.
    i_sys_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 0;
    rd(`WT_IDX_CONTROL, 8'h00, `WT_RESP_OKAY);
    check("level two request", o_irq_level_two, 0);
    rd(8'h10, 8'h00, `WT_RESP_SLVERR);
    wr(8'h10, 32'h5, `WT_RESP_SLVERR);
    @(posedge i_clk);
    if (q.size() != 0) fails++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
